// [bench/opc_dac_model.sv]
// Purpose: converter model at the chain output
// Assumes: one sample per out_valid pulse
// Notes: tracks extremes of accepted samples
`timescale 1ns/100ps
`default_nettype none
`include "opc_cfg.svh"
module opc_dac_model (
  // clock
  input wire logic              mclk,
  // sample in
  input wire logic              out_valid,
  input wire logic [`OPC_W-1:0] out_data,
  input wire logic              out_en
);
  import opc_pkg::*;
  logic signed [`OPC_W-1:0] max_q = 16'sh8000;
  logic signed [`OPC_W-1:0] min_q = 16'sh7fff;

  always @(posedge mclk) begin
    if (out_valid && out_en) begin
      if ($signed(out_data) > max_q)
        max_q <= out_data;
      if ($signed(out_data) < min_q)
        min_q <= out_data;
    end
  end
endmodule : opc_dac_model
`default_nettype wire

// [bench/opc_top_assertions.sv]
// Purpose: port checks of the precompensation chain
// Assumes: opc_cfg.svh on the include path
// Notes: ctrl and delay shadowed from register writes
`timescale 1ns/100ps
`default_nettype none
`include "opc_cfg.svh"
module opc_top_assertions #(
  parameter int unsigned UPD_CYC = 20
) (
  // clock and reset
  input wire logic               mclk,
  input wire logic               nrst,
  // register port
  input wire logic [`OPC_AW-1:0] reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // sequencer side
  input wire logic               in_valid,
  input wire logic [`OPC_W-1:0]  in_data,
  input wire logic               clear_pulse,
  input wire logic               lock_busy,
  // converter side
  input wire logic               out_valid,
  input wire logic [`OPC_W-1:0]  out_data,
  input wire logic               out_en,
  input wire logic               led_on
);
  import opc_pkg::*;
  logic [7:0] ctrl_q;
  logic [5:0] odly_q;
  logic       sclr_q;
  logic       clean_q;
  logic       lb_q;
  logic       full_q;
  logic       vis_q;
  logic [2:0] bcnt_q;
  wire logic  cw = reg_wr && reg_addr == `OPC_A_CTRL;
  wire logic  srd = reg_rd && reg_addr == `OPC_A_STAT;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q  <= 8'h00;
      odly_q  <= 6'h00;
      sclr_q  <= 1'b0;
      clean_q <= 1'b0;
      lb_q    <= 1'b0;
      full_q  <= 1'b0;
      vis_q   <= 1'b0;
      bcnt_q  <= 3'h0;
    end else begin
      if (cw)
        ctrl_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `OPC_A_ODLY)
        odly_q <= reg_wdata[5:0];
      sclr_q <= reg_wr && reg_addr == `OPC_A_SCLR && !ctrl_q[0];
      if (sclr_q)
        clean_q <= 1'b1;
      else if (cw && reg_wdata[0])
        clean_q <= 1'b0;
      if (out_valid && out_en)
        full_q <= out_data == 16'h7fff || out_data == 16'h8000;
      if (out_valid)
        vis_q <= out_en;
      lb_q <= lock_busy;
      if (lock_busy != lb_q)
        bcnt_q <= 3'h0;
      else if (bcnt_q != 3'h7)
        bcnt_q <= bcnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  led_mirror_a: assert property (led_on == out_en)
    else $error("panel indicator differs from output enable");
  on_write_a: assert property (cw ##1 !cw |=>
    out_en == $past(reg_wdata[`OPC_B_ON], 2))
    else $error("output enable misses control write");
  bypass_path_a: assert property (
    in_valid && !ctrl_q[0] && odly_q == 6'h00 && !reg_wr |=>
    out_valid && out_data == (out_en ? $past(in_data) : 16'h0000))
    else $error("chain off does not pass sample");
  chain_pass_a: assert property (
    in_valid && ctrl_q[4:0] == 5'h01 && odly_q == 6'h00 && out_en
    && !reg_wr |-> ##5 out_valid && out_data == $past(in_data, 5))
    else $error("disabled stages alter sample");
  latency_read_a: assert property (
    reg_rd && reg_addr == `OPC_A_LAT |=>
    reg_rdata == (ctrl_q[0] ? 32'(`OPC_CHAIN_LAT) : 32'h0))
    else $error("latency readback wrong");
  busy_read_a: assert property (
    srd && bcnt_q > 3'h4 |=> reg_rdata[9] == $past(lock_busy))
    else $error("busy flag wrong");
  clean_status_a: assert property (
    srd && clean_q |=> reg_rdata[7:0] == 8'h00)
    else $error("stage status not normal after clear");
  overload_read_a: assert property (
    srd && out_en && vis_q && !out_valid && !$past(out_valid)
    && !$past(out_valid, 2) |=> reg_rdata[8] == full_q)
    else $error("overload flag wrong");

  cover property (in_valid && ctrl_q[0]);
  cover property (srd && bcnt_q > 3'h4 && lock_busy);
  cover property (clear_pulse && ctrl_q[3]);
endmodule : opc_top_assertions

bind opc_top opc_top_assertions #(.UPD_CYC(UPD_CYC)) chk (
  .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .in_valid(in_valid), .in_data(in_data), .clear_pulse(clear_pulse),
  .lock_busy(lock_busy), .out_valid(out_valid), .out_data(out_data),
  .out_en(out_en), .led_on(led_on));
`default_nettype wire

// [bench/output_precompensation_chain_bench.sv]
// Purpose: self-checking bench of the precompensation chain
// Assumes: status update period shortened to 20 cycles
// Notes: one task per scenario, inputs driven on rising edges
`timescale 1ns/100ps
`default_nettype none
`include "opc_cfg.svh"
`define CHK(a, e, m) begin \
  checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("mismatch %0t %s", $time, m); \
  end \
end
module output_precompensation_chain_bench;
  import opc_pkg::*;
  logic               mclk = 1'b0;
  logic               nrst;
  logic [`OPC_AW-1:0] reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic               in_valid;
  logic [`OPC_W-1:0]  in_data;
  logic               clear_pulse;
  logic               lock_busy;
  logic               out_valid;
  logic [`OPC_W-1:0]  out_data;
  logic               out_en;
  logic               led_on;
  int                 fails = 0;
  int                 checks = 0;
  int                 cyc = 0;

  opc_top #(.UPD_CYC(20)) uut (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_data(in_data), .clear_pulse(clear_pulse),
    .lock_busy(lock_busy), .out_valid(out_valid), .out_data(out_data),
    .out_en(out_en), .led_on(led_on));
  opc_dac_model dac (
    .mclk(mclk), .out_valid(out_valid), .out_data(out_data), .out_en(out_en));

  always #10 mclk = ~mclk;

  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e, "read data")
  endtask : rd

  // ramp of 8 samples, output checked while input still flows
  task automatic stream(input int lat, input logic [15:0] b,
                        input logic on);
    for (int k = 0; k < 9; k++) begin
      @(posedge mclk);
      in_valid <= k < 8;
      in_data  <= b + 16'(k);
      #1;
      if (k > lat)
        `CHK(out_data, on ? b + 16'(k - lat) : 16'h0, "stream")
    end
  endtask : stream

  task automatic hold(input logic [15:0] x, input int n);
    repeat (n) begin
      @(posedge mclk);
      in_valid <= 1'b1;
      in_data  <= x;
    end
    @(posedge mclk);
    in_valid <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask : hold

  task automatic outs(input logic [1:0] e);
    repeat (2) @(posedge mclk);
    #1;
    `CHK({out_en, led_on}, e, "output enable")
  endtask : outs

  task automatic t_reset;
    rd(`OPC_A_CTRL, 32'h0);
    rd(`OPC_A_LAT, 32'h0);
    rd(`OPC_A_MAXMIN, 32'h80007fff);
    rd(`OPC_A_EXP, 32'h00080000);
    rd(`OPC_A_HP, 32'h8);
    rd(`OPC_A_STAT, 32'h0);
    rd(9'h024, 32'h0);
    rd(`OPC_A_COEF, 32'h0);
  endtask : t_reset

  task automatic t_bypass;
    wr(`OPC_A_CTRL, 32'h20);
    outs(2'b11);
    stream(1, 16'hf000, 1'b1);
    wr(`OPC_A_CTRL, 32'h3e);
    stream(1, 16'h1230, 1'b1);
    wr(`OPC_A_ODLY, 32'h3);
    stream(4, 16'h0100, 1'b1);
    wr(`OPC_A_ODLY, 32'h0);
  endtask : t_bypass

  task automatic t_fir;
    wr(`OPC_A_CTRL, 32'h21);
    rd(`OPC_A_LAT, 32'(`OPC_CHAIN_LAT));
    stream(5, 16'h0200, 1'b1);
    wr(`OPC_A_COEF, 32'h8000);
    wr(`OPC_A_COEF + 9'h020, 32'h10000);
    wr(`OPC_A_COEF + 9'h0a0, 32'h10000);
    wr(`OPC_A_CTRL, 32'h23);
    hold(16'h0400, 16);
    `CHK(out_data, 16'h0a00, "fir sum")
    rd(`OPC_A_STAT, 32'h0);
  endtask : t_fir

  task automatic t_ovf;
    hold(16'h7fff, 12);
    rd(`OPC_A_STAT, 32'h101);
    repeat (50) @(posedge mclk);
    rd(`OPC_A_STAT, 32'h102);
    wr(`OPC_A_CTRL, 32'h20);
    wr(`OPC_A_SCLR, 32'h1);
    rd(`OPC_A_STAT, 32'h100);
    rd(`OPC_A_MAXMIN, 32'h7ffff000);
    `CHK({dac.max_q, dac.min_q}, 32'h7ffff000, "dac range")
  endtask : t_ovf

  task automatic t_busy;
    wr(`OPC_A_CTRL, 32'h0);
    outs(2'b00);
    stream(1, 16'h0300, 1'b0);
    @(posedge mclk);
    lock_busy <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(`OPC_A_STAT, 32'h200);
    @(posedge mclk);
    lock_busy <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(`OPC_A_STAT, 32'h0);
  endtask : t_busy

  // pulse held high: only level mode keeps the integrator cleared
  task automatic t_slope;
    wr(`OPC_A_HP, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(`OPC_A_CTRL, 32'h29 | 32'(s) << 6);
      @(posedge mclk);
      clear_pulse <= 1'b1;
      hold(16'h2000, 24);
      `CHK(out_data == 16'h2000, s == 0, "clear reaction")
      @(posedge mclk);
      clear_pulse <= 1'b0;
    end
  endtask : t_slope

  initial begin
    nrst        = 1'b0;
    reg_addr    = 9'h000;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    in_valid    = 1'b0;
    in_data     = 16'h0000;
    clear_pulse = 1'b0;
    lock_busy   = 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_bypass();
    t_fir();
    t_ovf();
    t_busy();
    t_slope();
    stop_test();
  end
endmodule : output_precompensation_chain_bench
`default_nettype wire

// [include/opc_cfg.svh]
// Purpose: constants of the output precompensation chain
// Assumes: 50 MHz mclk, 16-bit signed samples, 9-bit register address
// Notes: offsets are byte addresses, one 32-bit word per register
// Function
// - 40 coefficients spread over 72 taps
// - fir stage runs at 1, bypassed at 0
// - master enable switches whole chain on or off
// - per-stage status: normal, recent overflow, past overflow
// - status-clear write resets all stage statuses
// - bounce stage: delay and relative amplitude, enabled
// - exponential stage: time constant, amplitude, enabled
// - high-pass stage: time constant, runs when enabled
// - clearing pulse reaction: level, rise, fall, both
// - chain latency readable
// - programmable output delay aligns channels
// - readable overload indicator on output
// - track readable max and min output
// - busy flag readable during blocking operation
// - output on bit also drives panel indicator
`ifndef OPC_CFG_SVH
`define OPC_CFG_SVH

`define OPC_W        16
`define OPC_NCOEF    40
`define OPC_NTAP     72
`define OPC_NDIR     8
`define OPC_CW       18
`define OPC_CFRAC    16
`define OPC_AFRAC    15
`define OPC_AW       9

`define OPC_CLK_HZ   50000000
`define OPC_UPD_MS   100
`define OPC_UPD_CYC  ((`OPC_CLK_HZ / 1000) * `OPC_UPD_MS)
`define OPC_FIR_LAT  1
`define OPC_CHAIN_LAT (`OPC_FIR_LAT + 3)

`define OPC_A_CTRL   9'h000
`define OPC_A_SCLR   9'h004
`define OPC_A_STAT   9'h008
`define OPC_A_EXP    9'h00c
`define OPC_A_HP     9'h010
`define OPC_A_BNC    9'h014
`define OPC_A_ODLY   9'h018
`define OPC_A_LAT    9'h01c
`define OPC_A_MAXMIN 9'h020
`define OPC_A_COEF   9'h100

`define OPC_B_CHAIN  0
`define OPC_B_FIR    1
`define OPC_B_EXP    2
`define OPC_B_HP     3
`define OPC_B_BNC    4
`define OPC_B_ON     5
`define OPC_B_SLOPE  6

`define OPC_COEF_ONE 18'h10000
`define OPC_TC_RST   4'h8
`define OPC_MAX_RST  16'h8000
`define OPC_MIN_RST  16'h7fff

`endif

// [include/opc_pkg.sv]
// Purpose: types of the output precompensation chain
// Assumes: opc_cfg.svh on the include path
// Notes: one packed state struct per module
`include "opc_cfg.svh"
package opc_pkg;

  typedef enum logic [1:0] {
    OPC_ST_OK   = 2'h0,
    OPC_ST_NOW  = 2'h1,
    OPC_ST_PAST = 2'h2
  } opc_stat_e;

  typedef enum logic [1:0] {
    OPC_SL_LEVEL = 2'h0,
    OPC_SL_RISE  = 2'h1,
    OPC_SL_FALL  = 2'h2,
    OPC_SL_BOTH  = 2'h3
  } opc_slope_e;

  typedef struct packed {
    logic                 seen;
    opc_stat_e            st;
  } opc_stat_s;

  typedef struct packed {
    logic [`OPC_NTAP-1:0][`OPC_W-1:0]   taps;
    logic [`OPC_NCOEF-1:0][`OPC_CW-1:0] coef;
    logic                               yv;
    logic [`OPC_W-1:0]                  y;
    logic                               ovf;
  } opc_fir_s;

  typedef struct packed {
    logic [7:0]            ctrl;
    logic [15:0]           exp_amp;
    logic [3:0]            exp_tc;
    logic [3:0]            hp_tc;
    logic [15:0]           bnc_amp;
    logic [5:0]            bnc_dly;
    logic [5:0]            out_dly;
    logic                  clr_prev;
    logic [22:0]           upd_cnt;
    logic                  tick;
    logic                  exp_v;
    logic                  hp_v;
    logic                  bnc_v;
    logic [31:0]           exp_lp;
    logic [39:0]           hp_int;
    logic [15:0]           exp_y;
    logic [15:0]           hp_y;
    logic [15:0]           bnc_y;
    logic [63:0][15:0]     bhist;
    logic [5:0]            bptr;
    logic [63:0][15:0]     odly;
    logic [5:0]            optr;
    logic [2:0]            ovf;
    logic                  out_valid;
    logic [15:0]           out_data;
    logic                  over;
    logic [15:0]           maxv;
    logic [15:0]           minv;
    logic [31:0]           rdata;
    logic [2:0]            bsync;
    logic                  busy;
  } opc_top_s;

  // saturate to 16 bits, msb flags a clip
  function automatic logic [16:0] opc_sat(input logic signed [47:0] v);
    if (v > 48'sh7fff) return {1'b1, 16'h7fff};
    if (v < -48'sh8000) return {1'b1, 16'h8000};
    return {1'b0, v[15:0]};
  endfunction : opc_sat

endpackage : opc_pkg

// [src/opc_fir.sv]
// Purpose: 72-tap fir stage with 40 shared coefficients
// Assumes: coefficients q2.16, one sample per en pulse
// Notes: one sample latency, bypass passes x unchanged
`timescale 1ns/100ps
`default_nettype none
`include "opc_cfg.svh"
module opc_fir (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // sample in
  input  wire logic                en,
  input  wire logic                byp,
  input  wire logic [`OPC_W-1:0]   x,
  // coefficient write
  input  wire logic                cw,
  input  wire logic [5:0]          cidx,
  input  wire logic [`OPC_CW-1:0]  cdata,
  // sample out
  output logic                     yv,
  output logic [`OPC_W-1:0]        y,
  output logic                     ovf
);
  import opc_pkg::*;

  opc_fir_s                         q, n;
  logic [`OPC_NTAP-1:0][`OPC_W-1:0] win;
  logic signed [33:0]               prod [`OPC_NTAP];
  logic signed [47:0]               acc;
  logic [16:0]                      s;

  assign win = {q.taps[`OPC_NTAP-2:0], x};

  // first taps own a coefficient, later ones share in pairs
  for (genvar t = 0; t < `OPC_NTAP; t++) begin : g_tap
    localparam int CI = (t < `OPC_NDIR) ? t
                      : `OPC_NDIR + (t - `OPC_NDIR) / 2;
    assign prod[t] = $signed(win[t]) * $signed(q.coef[CI]);
  end

  always_comb begin
    n = q;
    acc = '0;
    for (int i = 0; i < `OPC_NTAP; i++) acc = acc + 48'(prod[i]);
    s = opc_sat(acc >>> `OPC_CFRAC);
    n.yv  = en;
    n.ovf = 1'b0;
    if (en) begin
      n.taps = win;
      if (byp) begin
        n.y = x;
      end else begin
        n.y   = s[15:0];
        n.ovf = s[16];
      end
    end
    if (cw && cidx < 6'd40) n.coef[cidx] = cdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.coef[0] <= `OPC_COEF_ONE;
    end else begin
      q <= n;
    end
  end

  assign yv  = q.yv;
  assign y   = q.y;
  assign ovf = q.ovf;
endmodule : opc_fir
`default_nettype wire

// [src/opc_stat.sv]
// Purpose: overflow status tracker of one stage
// Assumes: tick marks the end of each update period
// Notes: overflow wins over a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module opc_stat (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // events
  input  wire logic          tick,
  input  wire logic          ovf,
  input  wire logic          clr,
  // status
  output var opc_pkg::opc_stat_e st
);
  import opc_pkg::*;

  opc_stat_s q, n;

  always_comb begin
    n = q;
    if (tick) begin
      n.seen = 1'b0;
      n.st   = q.seen ? OPC_ST_NOW
             : ((q.st == OPC_ST_OK) ? OPC_ST_OK : OPC_ST_PAST);
    end
    if (clr) begin
      n.seen = 1'b0;
      n.st   = OPC_ST_OK;
    end
    if (ovf) begin
      n.seen = 1'b1;
      n.st   = OPC_ST_NOW;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= n;
  end

  assign st = q.st;
endmodule : opc_stat
`default_nettype wire

// [src/opc_top.sv]
// Purpose: output precompensation chain of one channel
// Assumes: samples and clearing pulse on mclk, lock_busy asynchronous
// Notes: fir, exponential, high-pass and bounce stages in series
`timescale 1ns/100ps
`default_nettype none
`include "opc_cfg.svh"
module opc_top #(
  parameter int unsigned UPD_CYC = `OPC_UPD_CYC
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // register port
  input  wire logic [`OPC_AW-1:0]  reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  // samples from the sequencer
  input  wire logic                in_valid,
  input  wire logic [`OPC_W-1:0]   in_data,
  input  wire logic                clear_pulse,
  // blocking operation pin
  input  wire logic                lock_busy,
  // converter side
  output logic                     out_valid,
  output logic [`OPC_W-1:0]        out_data,
  output logic                     out_en,
  output logic                     led_on
);
  import opc_pkg::*;

  opc_top_s           q, n;
  logic [1:0]         rsync_q;
  logic               rst_n;
  logic               chain;
  logic               coef_wr;
  logic               st_clr;
  logic               fir_v;
  logic [15:0]        fir_y;
  logic               fir_ovf;
  logic [3:0]         ovf_v;
  opc_stat_e          st [4];
  logic signed [47:0] e_x;
  logic signed [47:0] e_lp;
  logic signed [47:0] lp_n;
  logic signed [47:0] e_y;
  logic signed [47:0] h_x;
  logic signed [47:0] h_y;
  logic signed [47:0] b_x;
  logic signed [47:0] b_y;
  logic [16:0]        e_s;
  logic [16:0]        h_s;
  logic [16:0]        b_s;
  logic [15:0]        bd;
  logic               hit;
  logic               fv;
  logic [15:0]        fsmp;
  logic [15:0]        dsmp;

  // reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rsync_q <= 2'h0;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  assign chain   = q.ctrl[`OPC_B_CHAIN];
  assign coef_wr = reg_wr && reg_addr[8] && (reg_addr[1:0] == 2'h0);
  assign st_clr  = reg_wr && (reg_addr == `OPC_A_SCLR);
  assign ovf_v   = {q.ovf, fir_ovf};

  // fir stage
  opc_fir u_fir (
    .clk   (mclk),
    .rst_n (rst_n),
    .en    (in_valid),
    .byp   (!chain || !q.ctrl[`OPC_B_FIR]),
    .x     (in_data),
    .cw    (coef_wr),
    .cidx  (reg_addr[7:2]),
    .cdata (reg_wdata[`OPC_CW-1:0]),
    .yv    (fir_v),
    .y     (fir_y),
    .ovf   (fir_ovf)
  );

  // one status tracker per stage
  for (genvar g = 0; g < 4; g++) begin : g_st
    opc_stat u_st (
      .clk   (mclk),
      .rst_n (rst_n),
      .tick  (q.tick),
      .ovf   (ovf_v[g]),
      .clr   (st_clr),
      .st    (st[g])
    );
  end

  always_comb begin
    n = q;
    dsmp = '0;
    hit = 1'b0;

    // update period divider
    n.tick = 1'b0;
    if (q.upd_cnt == 23'(UPD_CYC - 1)) begin
      n.upd_cnt = '0;
      n.tick    = 1'b1;
    end else begin
      n.upd_cnt = q.upd_cnt + 23'h1;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `OPC_A_CTRL: n.ctrl = reg_wdata[7:0];
        `OPC_A_EXP: begin
          n.exp_amp = reg_wdata[15:0];
          n.exp_tc  = reg_wdata[19:16];
        end
        `OPC_A_HP: n.hp_tc = reg_wdata[3:0];
        `OPC_A_BNC: begin
          n.bnc_amp = reg_wdata[15:0];
          n.bnc_dly = reg_wdata[21:16];
        end
        `OPC_A_ODLY: n.out_dly = reg_wdata[5:0];
        default: ;
      endcase
    end

    // register reads, data in the next cycle
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `OPC_A_CTRL: n.rdata = {24'h0, q.ctrl};
        `OPC_A_STAT:
          n.rdata = {22'h0, q.busy, q.over,
                     st[3], st[2], st[1], st[0]};
        `OPC_A_EXP: n.rdata = {12'h0, q.exp_tc, q.exp_amp};
        `OPC_A_HP: n.rdata = {28'h0, q.hp_tc};
        `OPC_A_BNC: n.rdata = {10'h0, q.bnc_dly, q.bnc_amp};
        `OPC_A_ODLY: n.rdata = {26'h0, q.out_dly};
        `OPC_A_LAT:
          n.rdata = chain ? 32'(`OPC_CHAIN_LAT) : 32'h0;
        `OPC_A_MAXMIN: n.rdata = {q.maxv, q.minv};
        default: n.rdata = '0;
      endcase
    end

    // exponential overshoot stage
    e_x  = 48'($signed(fir_y));
    e_lp = 48'($signed(q.exp_lp));
    lp_n = e_lp + (((e_x <<< 16) - e_lp) >>> q.exp_tc);
    e_y  = e_x + (((e_x - (e_lp >>> 16))
           * 48'($signed(q.exp_amp))) >>> `OPC_AFRAC);
    e_s  = opc_sat(e_y);
    n.exp_v = fir_v;
    n.ovf   = 3'h0;
    if (fir_v) begin
      n.exp_lp = lp_n[31:0];
      if (chain && q.ctrl[`OPC_B_EXP]) begin
        n.exp_y  = e_s[15:0];
        n.ovf[0] = e_s[16];
      end else begin
        n.exp_y = fir_y;
      end
    end

    // clearing pulse selection
    unique case (opc_slope_e'(q.ctrl[`OPC_B_SLOPE +: 2]))
      OPC_SL_LEVEL: hit = clear_pulse;
      OPC_SL_RISE:  hit = clear_pulse && !q.clr_prev;
      OPC_SL_FALL:  hit = !clear_pulse && q.clr_prev;
      OPC_SL_BOTH:  hit = clear_pulse != q.clr_prev;
    endcase
    n.clr_prev = clear_pulse;

    // high-pass compensation stage
    h_x = 48'($signed(q.exp_y));
    h_y = h_x + (48'($signed(q.hp_int)) >>> 16);
    h_s = opc_sat(h_y);
    n.hp_v = q.exp_v;
    if (hit) begin
      n.hp_int = '0;
    end else if (q.exp_v && chain && q.ctrl[`OPC_B_HP]) begin
      n.hp_int = q.hp_int + 40'((h_x <<< 16) >>> q.hp_tc);
    end
    if (q.exp_v) begin
      if (chain && q.ctrl[`OPC_B_HP]) begin
        n.hp_y   = h_s[15:0];
        n.ovf[1] = h_s[16];
      end else begin
        n.hp_y = q.exp_y;
      end
    end

    // bounce correction stage
    bd  = q.bhist[6'(q.bptr - q.bnc_dly)];
    b_x = 48'($signed(q.hp_y));
    b_y = b_x + ((48'($signed(bd))
          * 48'($signed(q.bnc_amp))) >>> `OPC_AFRAC);
    b_s = opc_sat(b_y);
    n.bnc_v = q.hp_v;
    if (q.hp_v) begin
      n.bhist[q.bptr] = q.hp_y;
      n.bptr          = q.bptr + 6'h1;
      if (chain && q.ctrl[`OPC_B_BNC]) begin
        n.bnc_y  = b_s[15:0];
        n.ovf[2] = b_s[16];
      end else begin
        n.bnc_y = q.hp_y;
      end
    end

    // chain select and output delay
    fv   = chain ? q.bnc_v : in_valid;
    fsmp = chain ? q.bnc_y : in_data;
    n.out_valid = fv;
    if (fv) begin
      n.odly[q.optr] = fsmp;
      n.optr         = q.optr + 6'h1;
      dsmp = (q.out_dly == 6'h0) ? fsmp
           : q.odly[6'(q.optr - q.out_dly)];
      n.out_data = q.ctrl[`OPC_B_ON] ? dsmp : 16'h0;
      n.over = (dsmp == 16'h7fff) || (dsmp == 16'h8000);
      if ($signed(dsmp) > $signed(q.maxv)) n.maxv = dsmp;
      if ($signed(dsmp) < $signed(q.minv)) n.minv = dsmp;
    end

    // busy pin, taken when second and third flop agree
    n.bsync = {q.bsync[1:0], lock_busy};
    if (q.bsync[1] == q.bsync[2]) n.busy = q.bsync[2];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.exp_tc <= `OPC_TC_RST;
      q.hp_tc  <= `OPC_TC_RST;
      q.maxv   <= `OPC_MAX_RST;
      q.minv   <= `OPC_MIN_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign out_valid = q.out_valid;
  assign out_data  = q.out_data;
  assign out_en    = q.ctrl[`OPC_B_ON];
  assign led_on    = q.ctrl[`OPC_B_ON];
endmodule : opc_top
`default_nettype wire
